// file: hdl/acq_seq_ctrl.sv
// Purpose: Acquisition mode, run state and record sequencing of the digitizer
// Assumes: Host command strobes and digitizer samples are on the i_mclk domain
// Notes:   Settings that shape a record, other than the time window, are refused while a process is busy
`timescale 1ns/10ps
module acq_seq_ctrl import acq_pkg::*; (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Host setting and state commands
  input wire cmd_t i_cmd,
  // Digitizer sample stream
  input wire smp_t i_smp,
  // Settings and state readback
  output cfg_t o_cfg,
  output status_t o_status,
  output logic o_cmd_err,
  // Operation-complete service request
  output logic o_opc,
  // Record memory write port
  output wr_t o_wr
);

  typedef struct packed {
    cfg_t cfg;
    status_t stat;
    logic [REC_W-1:0] dest;
    logic [REC_W-1:0] filled;
    logic [AVG_W-1:0] pass;
    logic opc;
    logic err;
  } ctl_t;

  localparam cfg_t CFG_RST = '{
    mode: MODE_NORMAL,
    time_ns: TIME_RST_NS,
    length: LEN_MID,
    record_count: REC_FIRST,
    start_record: REC_FIRST,
    single_then_stop: 1'b0,
    avg_count: AVG_RST
  };

  ctl_t s;
  ctl_t next_s;
  logic [IDX_W-1:0] last_idx;
  logic avg_mode;
  logic multi_mode;
  logic acq_done;
  logic proc_done;
  logic cmd_stop;
  smp_t acc_smp;

  assign last_idx = IDX_W'(s.cfg.length - LEN_W'(1));
  assign avg_mode = (s.cfg.mode == MODE_AVERAGE);
  assign multi_mode = (s.cfg.mode == MODE_MULTI);
  assign acq_done = s.stat.busy & i_smp.valid & (i_smp.idx == last_idx);
  assign proc_done = acq_done & ((!avg_mode && !multi_mode)
                     | (multi_mode && s.filled == s.cfg.record_count)
                     | (avg_mode && s.pass == s.cfg.avg_count));
  assign cmd_stop = i_cmd.valid & (i_cmd.code == CMD_STATE)
                    & (i_cmd.arg == ARG_W'(RUN_STOP));

  always_comb begin
    next_s = s;
    next_s.opc = 1'b0;
    next_s.err = 1'b0;

    if (acq_done) begin
      if (!avg_mode || s.pass == s.cfg.avg_count) begin
        next_s.stat.last_valid = s.dest;
      end
      if (proc_done) begin
        next_s.opc = 1'b1;
        next_s.stat.busy = 1'b0;
        if (s.stat.state == RUN_HOLD) begin
          next_s.stat.state = RUN_STOP;
        end
      end else if (multi_mode) begin
        next_s.dest = s.dest + REC_FIRST;
        next_s.filled = s.filled + REC_FIRST;
      end else begin
        next_s.pass = s.pass + AVG_MIN;
      end
    end else if (!s.stat.busy && s.stat.state != RUN_STOP) begin
      // first record is the start record
      next_s.stat.busy = 1'b1;
      next_s.dest = s.cfg.start_record;
      next_s.filled = REC_FIRST;
      next_s.pass = AVG_MIN;
    end

    if (i_cmd.valid) begin
      case (i_cmd.code)
        CMD_STATE: begin
          if (i_cmd.arg <= ARG_W'(RUN_HOLD)) begin
            next_s.stat.state = run_state_t'(i_cmd.arg[1:0]);
            if (cmd_stop) begin
              next_s.stat.busy = 1'b0;
            end
          end else begin
            next_s.err = 1'b1;
          end
        end
        CMD_MODE: begin
          if (!s.stat.busy && i_cmd.arg <= ARG_W'(MODE_AVERAGE)) begin
            next_s.cfg.mode = acq_mode_t'(i_cmd.arg[1:0]);
          end else begin
            next_s.err = 1'b1;
          end
        end
        CMD_TIME: begin
          if (i_cmd.arg >= ARG_W'(TIME_MIN_NS) && i_cmd.arg <= ARG_W'(TIME_MAX_NS)) begin
            next_s.cfg.time_ns = TIME_W'(i_cmd.arg);
          end else begin
            next_s.err = 1'b1;
          end
        end
        CMD_LENGTH: begin
          if (!s.stat.busy && (i_cmd.arg == ARG_W'(LEN_SHORT)
              || i_cmd.arg == ARG_W'(LEN_MID) || i_cmd.arg == ARG_W'(LEN_LONG))) begin
            next_s.cfg.length = LEN_W'(i_cmd.arg);
          end else begin
            next_s.err = 1'b1;
          end
        end
        CMD_NREC: begin
          if (!s.stat.busy && i_cmd.arg >= ARG_W'(REC_FIRST)
              && i_cmd.arg <= ARG_W'(REC_LAST)) begin
            next_s.cfg.record_count = REC_W'(i_cmd.arg);
          end else begin
            next_s.err = 1'b1;
          end
        end
        CMD_START: begin
          if (!s.stat.busy && i_cmd.arg >= ARG_W'(REC_FIRST)
              && i_cmd.arg <= ARG_W'(REC_LAST)) begin
            next_s.cfg.start_record = REC_W'(i_cmd.arg);
          end else begin
            next_s.err = 1'b1;
          end
        end
        CMD_HOLD: begin
          if (i_cmd.arg <= ARG_W'(1'b1)) begin
            next_s.cfg.single_then_stop = i_cmd.arg[0];
          end else begin
            next_s.err = 1'b1;
          end
        end
        CMD_AVG: begin
          if (!s.stat.busy && i_cmd.arg >= ARG_W'(AVG_MIN)
              && i_cmd.arg <= ARG_W'(AVG_MAX)) begin
            next_s.cfg.avg_count = AVG_W'(i_cmd.arg);
          end else begin
            next_s.err = 1'b1;
          end
        end
        default: begin
          next_s.err = 1'b1;
        end
      endcase
    end

    next_s.stat.res_bits = res_of(next_s.cfg.mode, next_s.cfg.avg_count);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{
        cfg: CFG_RST,
        stat: '{state: RUN_STOP, busy: 1'b0, last_valid: '0, res_bits: RES_11},
        dest: REC_FIRST,
        filled: REC_FIRST,
        pass: AVG_MIN,
        opc: 1'b0,
        err: 1'b0
      };
    end else begin
      s <= next_s;
    end
  end

  // Samples outside a running acquisition or past the record end are dropped
  assign acc_smp = '{
    valid: s.stat.busy & i_smp.valid & (i_smp.idx <= last_idx),
    idx: i_smp.idx,
    data: i_smp.data
  };

  avg_accum u_accum (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_smp(acc_smp),
    .i_first(!avg_mode || s.pass == AVG_MIN),
    .i_final(!avg_mode || s.pass == s.cfg.avg_count),
    .i_rec(s.dest),
    .i_div(avg_mode ? s.cfg.avg_count : AVG_MIN),
    .i_res_bits(s.stat.res_bits),
    .o_wr(o_wr)
  );

  assign o_cfg = s.cfg;
  assign o_status = s.stat;
  assign o_cmd_err = s.err;
  assign o_opc = s.opc;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  chk_normal_single: assert property (
    acq_done && s.cfg.mode == MODE_NORMAL && !i_cmd.valid
    |=> o_opc && o_status.last_valid == $past(s.dest) && !o_status.busy)
    else $error("normal acquisition did not finish its single record");

  chk_multi_begin: assert property (
    $rose(s.stat.busy) |-> s.dest == $past(s.cfg.start_record) && s.filled == REC_FIRST)
    else $error("process did not begin at the start record");

  chk_avg_hold_last: assert property (
    acq_done && avg_mode && s.pass != s.cfg.avg_count
    |=> $stable(o_status.last_valid) && !o_opc && s.pass == $past(s.pass) + AVG_MIN)
    else $error("partial average published or pass not advanced");

  chk_stop_abort: assert property (
    cmd_stop |=> !o_status.busy && o_status.state == RUN_STOP ##1 !o_status.busy)
    else $error("stop did not end the sequence at once");

  chk_run_restart: assert property (
    o_status.state == RUN_GO && !o_status.busy && !i_cmd.valid |=> o_status.busy)
    else $error("run state did not restart acquisition");

  chk_hold_stop: assert property (
    proc_done && s.stat.state == RUN_HOLD && !i_cmd.valid
    |=> o_status.state == RUN_STOP && o_opc ##1 !o_status.busy)
    else $error("hold-next did not stop after one process");

  chk_opc_pulse: assert property (
    o_opc |-> $past(proc_done) ##1 !o_opc)
    else $error("completion request without a finished process");

  chk_time_limits: assert property (
    o_cfg.time_ns >= TIME_MIN_NS && o_cfg.time_ns <= TIME_MAX_NS)
    else $error("time window out of range");

  chk_length_legal: assert property (
    o_cfg.length == LEN_SHORT || o_cfg.length == LEN_MID || o_cfg.length == LEN_LONG)
    else $error("illegal record length");

  chk_count_range: assert property (
    o_cfg.record_count >= REC_FIRST && o_cfg.record_count <= REC_LAST)
    else $error("record count out of range");

  chk_nv_mark: assert property (
    o_wr.valid |-> o_wr.rec == $past(s.dest) && o_wr.rec >= REC_FIRST
    && o_wr.nv == (o_wr.rec <= NV_LAST_REC))
    else $error("non-volatile marking wrong");

  chk_avg_range: assert property (
    o_cfg.avg_count >= AVG_MIN && o_cfg.avg_count <= AVG_MAX)
    else $error("averaging count out of range");

  chk_res_band: assert property (
    o_cfg.mode == MODE_AVERAGE && o_cfg.avg_count >= AVG_RES14 |-> o_status.res_bits == RES_14)
    else $error("resolution band wrong for large count");

  chk_last_cause: assert property (
    $changed(o_status.last_valid) |-> $past(acq_done))
    else $error("last valid record changed without a completion");

  chk_multi_step: assert property (
    acq_done && multi_mode && s.filled != s.cfg.record_count && !i_cmd.valid
    |=> s.dest == $past(s.dest) + REC_FIRST && o_status.busy)
    else $error("destination record did not multi_record_fill_mode");

  chk_state_legal: assert property (
    o_status.state inside {RUN_STOP, RUN_GO, RUN_HOLD})
    else $error("acquisition state readback not a legal state");

  chk_shape_frozen: assert property (
    $past(o_status.busy) |-> $stable(o_cfg.length) && $stable(o_cfg.mode)
    && $stable(o_cfg.start_record) && $stable(o_cfg.record_count))
    else $error("record shaping setting changed during a process");

  chk_mode_refused: assert property (
    i_cmd.valid && i_cmd.code == CMD_MODE && s.stat.busy
    |=> o_cmd_err && $stable(o_cfg.mode))
    else $error("mode change taken while a process was running");

  chk_start_range: assert property (
    o_cfg.start_record >= REC_FIRST && o_cfg.start_record <= REC_LAST)
    else $error("start record out of range");

  chk_idle_no_write: assert property (
    !$past(o_status.busy) |-> !o_wr.valid)
    else $error("record written outside a running process");

  chk_avg_publish: assert property (
    acq_done && avg_mode && s.pass == s.cfg.avg_count
    |=> o_opc && o_wr.valid && o_status.last_valid == $past(s.dest))
    else $error("final average pass did not publish its record");

  cov_multi_done: cover property (proc_done && multi_mode && s.cfg.record_count > REC_FIRST);
  cov_avg_done: cover property (proc_done && avg_mode && s.cfg.avg_count > AVG_MIN);
  cov_stop_busy: cover property (cmd_stop && s.stat.busy);
  cov_hold_end: cover property (proc_done && s.stat.state == RUN_HOLD);
  cov_run_restart: cover property (o_status.state == RUN_GO && $rose(o_status.busy));

endmodule

// file: hdl/acq_pkg.sv
// Purpose: Shared constants, types and helpers of the acquisition sequence control
// Assumes: Host commands and digitizer samples arrive on the i_mclk domain
// Notes:   Time window is held in whole nanoseconds
package acq_pkg;

  localparam int SMP_W = 10;
  localparam int IDX_W = 10;
  localparam int REC_W = 5;
  localparam int LEN_W = 11;
  localparam int AVG_W = 11;
  localparam int TIME_W = 17;
  localparam int ARG_W = 17;
  localparam int OUT_W = 14;
  localparam int RES_W = 4;
  localparam int SUM_W = SMP_W + AVG_W - 1;
  localparam int OUT_SHIFT = OUT_W - SMP_W;
  localparam int MEM_DEPTH = 1024;

  // Time window limits and reset, in ns
  localparam logic [TIME_W-1:0] TIME_MIN_NS = 17'h5;
  localparam logic [TIME_W-1:0] TIME_MAX_NS = 17'h1_86A0;
  localparam logic [TIME_W-1:0] TIME_RST_NS = 17'h3E8;

  // Record lengths in sample points
  localparam logic [LEN_W-1:0] LEN_SHORT = 11'h100;
  localparam logic [LEN_W-1:0] LEN_MID = 11'h200;
  localparam logic [LEN_W-1:0] LEN_LONG = 11'h400;

  // Record numbers and counts
  localparam logic [REC_W-1:0] REC_FIRST = 5'h1;
  localparam logic [REC_W-1:0] REC_LAST = 5'h10;
  localparam logic [REC_W-1:0] NV_LAST_REC = 5'h4;

  // Averaging count and resolution bands
  localparam logic [AVG_W-1:0] AVG_MIN = 11'h1;
  localparam logic [AVG_W-1:0] AVG_MAX = 11'h400;
  localparam logic [AVG_W-1:0] AVG_RST = 11'h10;
  localparam logic [AVG_W-1:0] AVG_RES12 = 11'h4;
  localparam logic [AVG_W-1:0] AVG_RES13 = 11'h10;
  localparam logic [AVG_W-1:0] AVG_RES14 = 11'h63;
  localparam logic [RES_W-1:0] RES_11 = 4'hB;
  localparam logic [RES_W-1:0] RES_12 = 4'hC;
  localparam logic [RES_W-1:0] RES_13 = 4'hD;
  localparam logic [RES_W-1:0] RES_14 = 4'hE;
  localparam logic [RES_W-1:0] RES_FULL = 4'hE;
  localparam logic [OUT_W-1:0] OUT_ONES = 14'h3FFF;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_MULTI, MODE_AVERAGE} acq_mode_t;
  typedef enum logic [1:0] {RUN_STOP, RUN_GO, RUN_HOLD} run_state_t;
  typedef enum logic [2:0] {
    CMD_MODE, CMD_STATE, CMD_TIME, CMD_LENGTH, CMD_NREC, CMD_START, CMD_HOLD, CMD_AVG
  } cmd_code_t;

  typedef struct packed {
    logic valid;
    cmd_code_t code;
    logic [ARG_W-1:0] arg;
  } cmd_t;

  typedef struct packed {
    acq_mode_t mode;
    logic [TIME_W-1:0] time_ns;
    logic [LEN_W-1:0] length;
    logic [REC_W-1:0] record_count;
    logic [REC_W-1:0] start_record;
    logic single_then_stop;
    logic [AVG_W-1:0] avg_count;
  } cfg_t;

  typedef struct packed {
    run_state_t state;
    logic busy;
    logic [REC_W-1:0] last_valid;
    logic [RES_W-1:0] res_bits;
  } status_t;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    logic [SMP_W-1:0] data;
  } smp_t;

  typedef struct packed {
    logic valid;
    logic nv;
    logic [REC_W-1:0] rec;
    logic [IDX_W-1:0] addr;
    logic [OUT_W-1:0] data;
  } wr_t;

  function automatic logic [RES_W-1:0] res_of(input acq_mode_t mode,
                                               input logic [AVG_W-1:0] cnt);
    if (mode != MODE_AVERAGE || cnt < AVG_RES12) return RES_11;
    if (cnt < AVG_RES13) return RES_12;
    if (cnt < AVG_RES14) return RES_13;
    return RES_14;
  endfunction

endpackage

// file: hdl/avg_accum.sv
// Purpose: Per-point sum store and record memory write stage
// Assumes: Sample index below MEM_DEPTH; divisor never zero
// Notes:   Sum store is read asynchronously, written on each accepted sample
`timescale 1ns/10ps
module avg_accum import acq_pkg::*; (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Accepted samples and pass control
  input wire smp_t i_smp,
  input wire logic i_first,
  input wire logic i_final,
  input wire logic [REC_W-1:0] i_rec,
  input wire logic [AVG_W-1:0] i_div,
  input wire logic [RES_W-1:0] i_res_bits,
  // Record memory write
  output wr_t o_wr
);

  logic [SUM_W-1:0] sum_mem [MEM_DEPTH];
  wr_t s;
  wr_t next_s;
  logic [SUM_W-1:0] sum;
  logic [SUM_W+OUT_SHIFT-1:0] quot;
  logic [OUT_W-1:0] mask;

  always_comb begin
    sum = i_first ? SUM_W'(i_smp.data) : sum_mem[i_smp.idx] + SUM_W'(i_smp.data);
    // Scale to full width first so the division keeps fraction bits
    quot = {sum, {OUT_SHIFT{1'b0}}} / (SUM_W + OUT_SHIFT)'(i_div);
    mask = OUT_ONES << (RES_FULL - i_res_bits);
    next_s.valid = i_smp.valid & i_final;
    next_s.nv = (i_rec <= NV_LAST_REC);
    next_s.rec = i_rec;
    next_s.addr = i_smp.idx;
    next_s.data = OUT_W'(quot) & mask;
  end

  always_ff @(posedge i_mclk) begin
    if (i_smp.valid) begin
      sum_mem[i_smp.idx] <= sum;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_wr = s;

endmodule

// file: tb/acq_host_model.sv
// Purpose: Host and sample source facing the acquisition control
// Assumes: Drives on the rising edge of i_mclk by non-blocking assignment
// Notes:   Idle sample lines show inverted data, never a stale value
`timescale 1ns/10ps
module acq_host_model import acq_pkg::*; (
  // Clock
  input wire logic i_mclk,
  // Commands and samples
  output cmd_t o_cmd,
  output smp_t o_smp
);
  initial begin
    o_cmd <= '0;
    o_smp <= '0;
  end

  task automatic send_cmd(input cmd_code_t code, input logic [ARG_W-1:0] arg);
    @(posedge i_mclk);
    o_cmd <= '{1'b1, code, arg};
    @(posedge i_mclk);
    o_cmd.valid <= 1'b0;
    #1;
  endtask

  // One sample a cycle, index 0 upward
  task automatic send_smp(input int n, input logic [SMP_W-1:0] v);
    for (int i = 0; i < n; i++) begin
      @(posedge i_mclk);
      o_smp <= '{1'b1, IDX_W'(i), v};
    end
    @(posedge i_mclk);
    o_smp <= '{1'b0, ~IDX_W'(n - 1), ~v};
    #1;
  endtask
endmodule

// file: tb/acq_seq_ctrl_test.sv
// Purpose: Self-checking bench of the acquisition sequence control
// Assumes: Record length 256 keeps the run short
// Notes:   Pulses are counted by a monitor, checks follow a settle delay
`timescale 1ns/10ps
module acq_seq_ctrl_test import acq_pkg::*; ;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  cmd_t cmd;
  smp_t smp;
  cfg_t cfg;
  status_t st;
  logic cmd_err;
  logic opc;
  wr_t wr;
  wr_t last_wr;
  int failures = 0;
  int cmp_count = 0;
  int opc_cnt = 0;
  int wr_cnt = 0;
  int bo;
  int bw;

  always #5 i_mclk = ~i_mclk;

  acq_host_model acq_host_model_i (.i_mclk(i_mclk), .o_cmd(cmd), .o_smp(smp));
  acq_seq_ctrl acq_seq_ctrl_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd(cmd),
    .i_smp(smp), .o_cfg(cfg), .o_status(st), .o_cmd_err(cmd_err), .o_opc(opc),
    .o_wr(wr));

  always @(posedge i_mclk) begin
    if (opc === 1'b1) opc_cnt++;
    if (wr.valid === 1'b1) begin
      wr_cnt++;
      last_wr = wr;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic do_cmd(input cmd_code_t c, input logic [ARG_W-1:0] a, input logic e);
    acq_host_model_i.send_cmd(c, a);
    chk("cmd_err", e, cmd_err);
  endtask

  task automatic wait_busy();
    int n;
    n = 0;
    while (st.busy !== 1'b1 && n < 50) begin
      idle(1);
      n++;
    end
    if (st.busy !== 1'b1) begin
      chk("busy", 1'b1, st.busy);
      complete_run();
    end
  endtask

  task automatic start_hold();
    bo = opc_cnt;
    bw = wr_cnt;
    do_cmd(CMD_STATE, 17'h2, 1'b0);
    chk("state", RUN_HOLD, st.state);
    wait_busy();
  endtask

  task automatic t_reset();
    chk("mode", MODE_NORMAL, cfg.mode);
    chk("time", TIME_RST_NS, cfg.time_ns);
    chk("length", LEN_MID, cfg.length);
    chk("nrec", REC_FIRST, cfg.record_count);
    chk("start", REC_FIRST, cfg.start_record);
    chk("hold", 1'b0, cfg.single_then_stop);
    chk("avg", AVG_RST, cfg.avg_count);
    chk("state", RUN_STOP, st.state);
    chk("last", 5'h0, st.last_valid);
    chk("res", RES_11, st.res_bits);
  endtask

  task automatic t_config();
    cmd_code_t bc[11] = '{CMD_TIME, CMD_TIME, CMD_LENGTH, CMD_NREC, CMD_NREC, CMD_START,
      CMD_START, CMD_AVG, CMD_AVG, CMD_HOLD, CMD_MODE};
    logic [ARG_W-1:0] ba[11] = '{17'h4, 17'h1_86A1, 17'h12C, 17'h0, 17'h11, 17'h0,
      17'h11, 17'h0, 17'h401, 17'h2, 17'h3};
    for (int i = 0; i < 11; i++) do_cmd(bc[i], ba[i], 1'b1);
    do_cmd(CMD_STATE, 17'h3, 1'b1);
    chk("cfg", {MODE_NORMAL, TIME_RST_NS, AVG_RST, 1'b0},
      {cfg.mode, cfg.time_ns, cfg.avg_count, cfg.single_then_stop});
    do_cmd(CMD_TIME, 17'h5, 1'b0);
    chk("time", TIME_MIN_NS, cfg.time_ns);
    do_cmd(CMD_TIME, 17'h1_86A0, 1'b0);
    chk("time", TIME_MAX_NS, cfg.time_ns);
    do_cmd(CMD_LENGTH, 17'h400, 1'b0);
    chk("length", LEN_LONG, cfg.length);
    do_cmd(CMD_LENGTH, 17'h100, 1'b0);
    chk("length", LEN_SHORT, cfg.length);
    do_cmd(CMD_NREC, 17'h10, 1'b0);
    chk("nrec", REC_LAST, cfg.record_count);
    do_cmd(CMD_AVG, 17'h400, 1'b0);
    chk("avg", AVG_MAX, cfg.avg_count);
    chk("res", RES_11, st.res_bits);
  endtask

  task automatic t_normal();
    do_cmd(CMD_START, 17'h5, 1'b0);
    chk("start", 5'h5, cfg.start_record);
    start_hold();
    do_cmd(CMD_HOLD, 17'h1, 1'b0);
    chk("hold", 1'b1, cfg.single_then_stop);
    acq_host_model_i.send_smp(256, 10'h2AA);
    idle(2);
    chk("opc", bo + 1, opc_cnt);
    chk("wr count", bw + 256, wr_cnt);
    chk("wr", {5'h5, 1'b0, 10'h0FF, 14'h2AA0},
      {last_wr.rec, last_wr.nv, last_wr.addr, last_wr.data});
    chk("last", 5'h5, st.last_valid);
    chk("stopped", {RUN_STOP, 1'b0}, {st.state, st.busy});
  endtask

  task automatic t_multi();
    do_cmd(CMD_MODE, 17'h1, 1'b0);
    do_cmd(CMD_NREC, 17'h2, 1'b0);
    do_cmd(CMD_START, 17'h3, 1'b0);
    start_hold();
    acq_host_model_i.send_smp(256, 10'h011);
    idle(1);
    chk("wr rec", 5'h3, last_wr.rec);
    chk("last", 5'h3, st.last_valid);
    chk("opc", bo, opc_cnt);
    acq_host_model_i.send_smp(256, 10'h011);
    idle(2);
    chk("wr", {5'h4, 1'b1}, {last_wr.rec, last_wr.nv});
    chk("wr count", bw + 512, wr_cnt);
    chk("last", 5'h4, st.last_valid);
    chk("opc", bo + 1, opc_cnt);
    chk("state", RUN_STOP, st.state);
  endtask

  task automatic t_average();
    logic [ARG_W-1:0] aa[6] = '{17'h3, 17'h4, 17'hF, 17'h10, 17'h62, 17'h63};
    logic [RES_W-1:0] ar[6] = '{RES_11, RES_12, RES_12, RES_13, RES_13, RES_14};
    do_cmd(CMD_MODE, 17'h2, 1'b0);
    for (int i = 0; i < 6; i++) begin
      do_cmd(CMD_AVG, aa[i], 1'b0);
      chk("res", ar[i], st.res_bits);
    end
    do_cmd(CMD_AVG, 17'h4, 1'b0);
    do_cmd(CMD_START, 17'h2, 1'b0);
    start_hold();
    repeat (3) acq_host_model_i.send_smp(256, 10'h155);
    idle(1);
    chk("wr count", bw, wr_cnt);
    acq_host_model_i.send_smp(256, 10'h155);
    idle(2);
    chk("wr count", bw + 256, wr_cnt);
    chk("wr", {5'h2, 14'h1550}, {last_wr.rec, last_wr.data});
    chk("opc", bo + 1, opc_cnt);
    chk("last", 5'h2, st.last_valid);
  endtask

  task automatic t_run_stop();
    do_cmd(CMD_MODE, 17'h0, 1'b0);
    do_cmd(CMD_START, 17'h6, 1'b0);
    bo = opc_cnt;
    bw = wr_cnt;
    do_cmd(CMD_STATE, 17'h1, 1'b0);
    chk("state", RUN_GO, st.state);
    wait_busy();
    acq_host_model_i.send_smp(256, 10'h0F0);
    idle(2);
    chk("opc", bo + 1, opc_cnt);
    chk("last", 5'h6, st.last_valid);
    wait_busy();
    chk("state", RUN_GO, st.state);
    acq_host_model_i.send_smp(10, 10'h0F0);
    do_cmd(CMD_MODE, 17'h2, 1'b1);
    chk("mode", MODE_NORMAL, cfg.mode);
    do_cmd(CMD_STATE, 17'h0, 1'b0);
    chk("stopped", {RUN_STOP, 1'b0}, {st.state, st.busy});
    acq_host_model_i.send_smp(256, 10'h0F0);
    idle(2);
    chk("opc", bo + 1, opc_cnt);
    chk("wr count", bw + 266, wr_cnt);
    chk("last", 5'h6, st.last_valid);
  endtask

  // Reset in mid-process must return every setting to its reset value
  task automatic t_mid_reset();
    do_cmd(CMD_STATE, 17'h1, 1'b0);
    wait_busy();
    acq_host_model_i.send_smp(10, 10'h0F0);
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    #1;
    t_reset();
    chk("busy", 1'b0, st.busy);
  endtask

  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    #1;
    t_reset();
    t_config();
    t_normal();
    t_multi();
    t_average();
    t_run_stop();
    t_mid_reset();
    complete_run();
  end
endmodule
